// [core/gtm_pkg.sv]
package gtm_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] GTM_OFS_CONTROL     = 3'h0;
    localparam logic [2:0] GTM_OFS_GATE_CTRL   = 3'h1;
    localparam logic [2:0] GTM_OFS_CLK_SEL     = 3'h2;
    localparam logic [2:0] GTM_OFS_GATE_SEL    = 3'h3;
    localparam logic [2:0] GTM_OFS_COUNT_LOW   = 3'h4;
    localparam logic [2:0] GTM_OFS_COUNT_HIGH  = 3'h5;
    localparam logic [2:0] GTM_OFS_FLAGS       = 3'h6;

    // timer_control fields
    localparam int GTM_CTL_ON_BIT    = 0;
    localparam int GTM_CTL_BUFFERED_READ_ENABLE_BIT  = 1;
    localparam int GTM_CTL_SYNC_BIT  = 2;
    localparam int GTM_CTL_PS_LSB    = 4;
    // timer_gate_control fields
    localparam int GTM_GC_ARMED_BIT  = 3;
    localparam int GTM_GC_SPM_BIT    = 4;
    localparam int GTM_GC_TGL_BIT    = 5;
    localparam int GTM_GC_POL_BIT    = 6;
    localparam int GTM_GC_GE_BIT     = 7;
    localparam int GTM_GC_GATE_LEVEL_STATUS_BIT   = 2;
    // flags register fields (write 1 to clear)
    localparam int GTM_FL_OVF_BIT    = 0;
    localparam int GTM_FL_GATE_BIT   = 1;

    localparam logic [7:0] GTM_RST_BYTE  = 8'h00;
    localparam logic [3:0] GTM_CS_PIN    = 4'h0;
    localparam logic [3:0] GTM_CS_FOSC4  = 4'h1;
    localparam logic [3:0] GTM_CS_FOSC   = 4'h2;
    localparam logic [3:0] GTM_CS_SELF   = 4'h9;
    localparam logic [4:0] GTM_GS_SELF   = 5'h02;
    localparam logic [4:0] GTM_GS_LAST   = 5'h18;
    localparam logic [1:0] GTM_FOSC4_DIV = 2'h3;

    typedef struct packed {
        logic       gate_function_enable;
        logic       gate_polarity;
        logic       gate_toggle_mode;
        logic       gate_single_pulse_mode;
    } gtm_gate_cfg_s;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gtm_bus_s;

endpackage : gtm_pkg

// [core/gtm_timer.sv]
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module gtm_timer #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rst_b_i,
    // register port
    input  wire gtm_pkg::gtm_bus_s   bus_i,
    output logic [7:0]               rdata_o,
    // clock sources, codes 0..15 (indices 0..2 absent: pin, fosc/4, fosc)
    input  wire logic                routed_clock_pin_i,
    input  wire logic [15:3]         clk_src_i,
    // gate sources, codes 0..24 (index 0 unused: pin)
    input  wire logic                routed_gate_pin_i,
    input  wire logic [24:1]         gate_src_i,
    // events
    output logic                     overflow_pulse_o,
    output logic                     overflow_flag_o,
    output logic                     gate_event_flag_o
);
    import gtm_pkg::*;

    // one address compare shared by every strobe decode below
    function automatic logic reg_hit(input gtm_bus_s b, input logic [2:0] ofs);
        return b.addr == ofs;
    endfunction : reg_hit

    // reserved gate codes: own overflow and everything past the last source
    function automatic logic gate_code_reserved(input logic [4:0] code);
        return (code == GTM_GS_SELF) || (code > GTM_GS_LAST);
    endfunction : gate_code_reserved

    logic [1:0]       prescale_select_reg;
    logic             sync_disable_reg;
    logic             buffered_read_enable_reg;
    logic             timer_on_reg;
    gtm_gate_cfg_s    gate_cfg_reg;
    logic             single_pulse_armed_reg;
    logic [3:0]       clk_sel_reg;
    logic [4:0]       gate_source_select_reg;
    logic [CNT_W-1:0] count_reg;
    logic [7:0]       high_hold_reg;
    logic             overflow_flag_reg;
    logic             gate_event_flag_reg;
    logic [1:0]       fosc4_cnt_reg;
    logic             clk_meta_reg;
    logic             clk_sync_reg;
    logic             clk_prev_reg;
    logic [2:0]       ps_cnt_reg;
    logic             gate_prev_reg;
    logic             toggle_ff_reg;
    logic             gate_level_status_prev_reg;
    logic             pulse_open_reg;

    logic             wr_ctl;
    logic             wr_gc;
    logic             wr_lo;
    logic             wr_hi;
    logic             wr_cs;
    logic             wr_gs;
    logic             wr_fl;
    logic             rd_lo;
    logic             ps_wrap;
    logic             sel_raw;
    logic             sys_src;
    logic             src_level;
    logic             src_rise;
    logic             tick;
    logic             gate_raw;
    logic             gate_pol;
    logic             gate_rise;
    logic             gate_value;
    logic             count_ok;
    logic             inc;
    logic [2:0]       ps_mask;

    always_comb begin
        wr_ctl = bus_i.wr && reg_hit(bus_i, GTM_OFS_CONTROL);
        wr_gc  = bus_i.wr && reg_hit(bus_i, GTM_OFS_GATE_CTRL);
        wr_cs  = bus_i.wr && reg_hit(bus_i, GTM_OFS_CLK_SEL);
        wr_gs  = bus_i.wr && reg_hit(bus_i, GTM_OFS_GATE_SEL);
        wr_lo  = bus_i.wr && reg_hit(bus_i, GTM_OFS_COUNT_LOW);
        wr_hi  = bus_i.wr && reg_hit(bus_i, GTM_OFS_COUNT_HIGH);
        wr_fl  = bus_i.wr && reg_hit(bus_i, GTM_OFS_FLAGS);
        rd_lo  = bus_i.rd && reg_hit(bus_i, GTM_OFS_COUNT_LOW);
    end

    // clock source mux; own overflow code selects nothing
    always_comb begin
        unique case (clk_sel_reg)
            GTM_CS_PIN:   sel_raw = routed_clock_pin_i;
            GTM_CS_FOSC4: sel_raw = 1'b0;
            GTM_CS_FOSC:  sel_raw = 1'b0;
            GTM_CS_SELF:  sel_raw = 1'b0;
            default:      sel_raw = clk_src_i[clk_sel_reg];
        endcase
    end

    assign sys_src = (clk_sel_reg == GTM_CS_FOSC) || (clk_sel_reg == GTM_CS_FOSC4);

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            clk_meta_reg <= 1'b0;
            clk_sync_reg <= 1'b0;
            clk_prev_reg <= 1'b0;
        end else begin
            clk_meta_reg <= sel_raw;
            clk_sync_reg <= clk_meta_reg;
            clk_prev_reg <= src_level;
        end
    end

    // unsynchronised path still edge-detected on core clock; it only skips the
    // two-stage synchroniser, so a caller must accept metastability risk
    assign src_level = sync_disable_reg ? sel_raw : clk_sync_reg;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            fosc4_cnt_reg <= 2'h0;
        else
            fosc4_cnt_reg <= fosc4_cnt_reg + 2'h1;
    end

    always_comb begin
        src_rise = src_level && !clk_prev_reg;
        // internal clocks need no synchroniser, so the sync bit has no say here
        if (sys_src)
            src_rise = (clk_sel_reg == GTM_CS_FOSC) || (fosc4_cnt_reg == GTM_FOSC4_DIV);
    end

    // prescaler
    always_comb begin
        unique case (prescale_select_reg)
            2'h0: ps_mask = 3'h0;
            2'h1: ps_mask = 3'h1;
            2'h2: ps_mask = 3'h3;
            2'h3: ps_mask = 3'h7;
        endcase
    end

    // masked compare still finds the wrap when the field shrinks mid-run
    assign ps_wrap = (ps_cnt_reg & ps_mask) == ps_mask;

    // stopped timer restarts the prescaler from a known phase
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || !timer_on_reg)
            ps_cnt_reg <= 3'h0;
        else if (src_rise)
            ps_cnt_reg <= ps_wrap ? 3'h0 : ps_cnt_reg + 3'h1;
    end

    assign tick = src_rise && ps_wrap;

    // gate source mux
    always_comb begin
        if (gate_source_select_reg == 5'h00)
            gate_raw = routed_gate_pin_i;
        else if (gate_code_reserved(gate_source_select_reg))
            gate_raw = 1'b0;
        else
            gate_raw = gate_src_i[gate_source_select_reg];
    end

    assign gate_pol  = gate_cfg_reg.gate_polarity ? gate_raw : !gate_raw;
    assign gate_rise = gate_pol && !gate_prev_reg;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            gate_prev_reg <= 1'b0;
        else
            gate_prev_reg <= gate_pol;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || !timer_on_reg || !gate_cfg_reg.gate_toggle_mode)
            toggle_ff_reg <= 1'b0;
        else if (gate_rise)
            toggle_ff_reg <= !toggle_ff_reg;
    end

    // single pulse: armed waits for the leading edge, then pulse_open counts
    // until the trailing edge; further gate events are ignored until re-arm
    logic stage_gate;
    logic stage_prev_reg;
    logic stage_rise;
    logic stage_fall;
    assign stage_gate = gate_cfg_reg.gate_toggle_mode ? toggle_ff_reg : gate_pol;
    assign stage_rise = stage_gate && !stage_prev_reg;
    assign stage_fall = !stage_gate && stage_prev_reg;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            stage_prev_reg <= 1'b0;
        else
            stage_prev_reg <= stage_gate;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i || !gate_cfg_reg.gate_single_pulse_mode)
            pulse_open_reg <= 1'b0;
        else if (single_pulse_armed_reg && stage_rise)
            pulse_open_reg <= 1'b1;
        else if (stage_fall)
            pulse_open_reg <= 1'b0;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            single_pulse_armed_reg <= 1'b0;
        else if (!gate_cfg_reg.gate_single_pulse_mode ||
                 (wr_gc && !bus_i.wdata[GTM_GC_SPM_BIT]))
            single_pulse_armed_reg <= 1'b0;
        else if (pulse_open_reg && stage_fall)
            single_pulse_armed_reg <= 1'b0;
        else if (wr_gc)
            single_pulse_armed_reg <= bus_i.wdata[GTM_GC_ARMED_BIT];
    end

    // gate value seen by the counter
    assign gate_value = gate_cfg_reg.gate_single_pulse_mode ?
                        (pulse_open_reg && stage_gate) : stage_gate;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            gate_level_status_prev_reg <= 1'b0;
        else
            gate_level_status_prev_reg <= gate_value;
    end

    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            gate_event_flag_reg <= 1'b0;
        else if (gate_level_status_prev_reg && !gate_value)
            gate_event_flag_reg <= 1'b1;
        else if (wr_fl && bus_i.wdata[GTM_FL_GATE_BIT])
            gate_event_flag_reg <= 1'b0;
    end

    assign count_ok = !gate_cfg_reg.gate_function_enable || gate_value;
    assign inc      = timer_on_reg && tick && count_ok;

    // a software write beats a same-cycle increment, so a preload never races
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            count_reg <= '0;
        else if (wr_lo)
            count_reg[7:0] <= bus_i.wdata;
        else if (wr_hi)
            count_reg[CNT_W-1:8] <= bus_i.wdata[CNT_W-9:0];
        else if (inc)
            count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end

    // a wrap hidden by a byte write is no wrap at all
    assign overflow_pulse_o = inc && (&count_reg) && !wr_lo && !wr_hi;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            overflow_flag_reg <= 1'b0;
        else if (overflow_pulse_o)
            overflow_flag_reg <= 1'b1;
        else if (wr_fl && bus_i.wdata[GTM_FL_OVF_BIT])
            overflow_flag_reg <= 1'b0;
    end

    // latched on every low read; only shown when buffering is on
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            high_hold_reg <= GTM_RST_BYTE;
        else if (rd_lo)
            high_hold_reg <= count_reg[15:8];
    end

    // control registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            prescale_select_reg      <= 2'h0;
            sync_disable_reg         <= 1'b0;
            buffered_read_enable_reg <= 1'b0;
            timer_on_reg             <= 1'b0;
        end else if (wr_ctl) begin
            prescale_select_reg      <= bus_i.wdata[GTM_CTL_PS_LSB +: 2];
            sync_disable_reg         <= bus_i.wdata[GTM_CTL_SYNC_BIT];
            buffered_read_enable_reg <= bus_i.wdata[GTM_CTL_BUFFERED_READ_ENABLE_BIT];
            timer_on_reg             <= bus_i.wdata[GTM_CTL_ON_BIT];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            gate_cfg_reg <= '0;
        else if (wr_gc)
            gate_cfg_reg <= bus_i.wdata[7:4];
    end

    // reserved codes are stored as written; the muxes turn them into a quiet 0
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            clk_sel_reg <= GTM_CS_PIN;
        else if (wr_cs)
            clk_sel_reg <= bus_i.wdata[3:0];
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            gate_source_select_reg <= 5'h00;
        else if (wr_gs)
            gate_source_select_reg <= bus_i.wdata[4:0];
    end

    // read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i)
            rdata_o <= GTM_RST_BYTE;
        else if (!bus_i.rd)
            rdata_o <= GTM_RST_BYTE;
        else begin
            unique case (bus_i.addr)
                GTM_OFS_CONTROL:    rdata_o <= {2'h0, prescale_select_reg, 1'b0, sync_disable_reg,
                                                buffered_read_enable_reg, timer_on_reg};
                GTM_OFS_GATE_CTRL:  rdata_o <= {gate_cfg_reg, single_pulse_armed_reg,
                                                gate_value, 2'h0};
                GTM_OFS_CLK_SEL:    rdata_o <= {4'h0, clk_sel_reg};
                GTM_OFS_GATE_SEL:   rdata_o <= {3'h0, gate_source_select_reg};
                GTM_OFS_COUNT_LOW:  rdata_o <= count_reg[7:0];
                GTM_OFS_COUNT_HIGH: rdata_o <= buffered_read_enable_reg ?
                                               high_hold_reg : count_reg[15:8];
                GTM_OFS_FLAGS:      rdata_o <= {6'h00, gate_event_flag_reg, overflow_flag_reg};
                default:            rdata_o <= GTM_RST_BYTE;
            endcase
        end
    end

    assign overflow_flag_o   = overflow_flag_reg;
    assign gate_event_flag_o = gate_event_flag_reg;

endmodule : gtm_timer
`default_nettype wire

// [dv/gtm_far_model.sv]
`timescale 1ns/1ns
`default_nettype none
module gtm_far_model (
    // clock
    input  wire logic   core_clk_i,
    // sources toward the timer
    output logic        clk_pin_o,
    output logic [15:3] clk_src_o,
    output logic        gate_pin_o,
    output logic [24:1] gate_src_o
);
    logic [2:0] div_q = 3'h0;
    initial begin
        clk_pin_o  = 1'b0;
        clk_src_o  = '0;
        gate_pin_o = 1'b0;
        gate_src_o = '0;
    end
    // pin clock locked to the core clock so edge counts per window are exact
    always @(posedge core_clk_i) begin
        div_q      <= div_q + 3'h1;
        clk_pin_o  <= clk_pin_o ^ (div_q == 3'h7);
        clk_src_o  <= 13'($urandom);
        gate_src_o <= 24'($urandom);
    end
    task automatic set_gate(input logic level);
        @(posedge core_clk_i);
        gate_pin_o <= level;
    endtask : set_gate
endmodule : gtm_far_model
`default_nettype wire

// [dv/gtm_timer_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module gtm_timer_asserts
    import gtm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    // register port
    input  wire gtm_bus_s   bus_i,
    input  wire logic [7:0] rdata_o,
    // events
    input  wire logic       overflow_pulse_o,
    input  wire logic       overflow_flag_o,
    input  wire logic       gate_event_flag_o
);
    import gtm_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic ovf_clr;
    logic gev_clr;
    assign ovf_clr = bus_i.wr && bus_i.addr == GTM_OFS_FLAGS && bus_i.wdata[GTM_FL_OVF_BIT];
    assign gev_clr = bus_i.wr && bus_i.addr == GTM_OFS_FLAGS && bus_i.wdata[GTM_FL_GATE_BIT];

    rdata_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a reply");
    reset_clear_a: assert property (disable iff (1'b0) !rst_b_i |=> !overflow_flag_o && !gate_event_flag_o)
        else $error("flags not cleared by reset");
    unmapped_zero_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 3'h7 |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    ctl_upper_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == GTM_OFS_CONTROL |-> rdata_o[7:6] == 2'b00 && !rdata_o[3])
        else $error("control spare bits not zero");
    sel_upper_a: assert property ($past(bus_i.rd) |-> !($past(bus_i.addr) == GTM_OFS_CLK_SEL && |rdata_o[7:4]) && !($past(bus_i.addr) == GTM_OFS_GATE_SEL && |rdata_o[7:5]) && !($past(bus_i.addr) == GTM_OFS_GATE_CTRL && |rdata_o[1:0]))
        else $error("select or gate control spare bits not zero");
    ovf_flag_set_a: assert property (overflow_pulse_o |=> overflow_flag_o)
        else $error("overflow flag not set after wrap");
    ovf_flag_cause_a: assert property ($rose(overflow_flag_o) |-> $past(overflow_pulse_o))
        else $error("overflow flag set without wrap");
    ovf_flag_hold_a: assert property (overflow_flag_o && !ovf_clr |=> overflow_flag_o)
        else $error("overflow flag lost without clear");
    ovf_flag_clear_a: assert property (ovf_clr && !overflow_pulse_o |=> !overflow_flag_o)
        else $error("overflow flag not cleared");
    gate_flag_hold_a: assert property (gate_event_flag_o && !gev_clr |=> gate_event_flag_o)
        else $error("gate event flag lost without clear");
    ovf_pulse_once_a: assert property (overflow_pulse_o && !bus_i.wr |=> !overflow_pulse_o)
        else $error("overflow pulse longer than one cycle");
endmodule : gtm_timer_asserts

bind gtm_timer gtm_timer_asserts #(.CNT_W(CNT_W)) u_asserts (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .overflow_pulse_o(overflow_pulse_o), .overflow_flag_o(overflow_flag_o),
    .gate_event_flag_o(gate_event_flag_o)
);
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import gtm_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_b_i    = 1'b0;
    gtm_bus_s    bus        = '0;
    logic [7:0]  rdata;
    logic        clk_pin;
    logic [15:3] clk_src;
    logic        gate_pin;
    logic [24:1] gate_src;
    logic        ovf_pulse;
    logic        ovf_flag;
    logic        gate_flag;
    logic        rd_seen    = 1'b0;
    logic [7:0]  cap;
    logic [15:0] exp_q[$];
    int          mismatches = 0;
    int          compares   = 0;
    int          cycles     = 0;
    int          per[3]     = '{16, 4, 1};
    logic [2:0]  ra[4]      = '{3'h0, 3'h2, 3'h3, 3'h7};
    logic [7:0]  rm[4]      = '{8'h36, 8'h0F, 8'h1F, 8'h00};

    always #10 core_clk_i = ~core_clk_i;

    gtm_timer dut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
        .routed_clock_pin_i(clk_pin), .clk_src_i(clk_src),
        .routed_gate_pin_i(gate_pin), .gate_src_i(gate_src),
        .overflow_pulse_o(ovf_pulse), .overflow_flag_o(ovf_flag),
        .gate_event_flag_o(gate_flag)
    );
    gtm_far_model u_far (
        .core_clk_i(core_clk_i), .clk_pin_o(clk_pin), .clk_src_o(clk_src),
        .gate_pin_o(gate_pin), .gate_src_o(gate_src)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        bus <= '0;
    endtask : wr

    // mask 0 only captures the value for a later relative expectation
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge core_clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back({m, e & m});
        @(posedge core_clk_i);
        bus <= '0;
        #1 cap = rdata;
    endtask : rd

    always @(posedge core_clk_i) begin
        logic [15:0] e;
        rd_seen <= bus.rd;
        if (rd_seen) begin
            e = exp_q.pop_front();
            if (e[15:8] !== 8'h00) check(rdata & e[15:8], e[7:0]);
        end
    end

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        logic [7:0] d;
        void'($urandom(32'h0AD20B50));
        repeat (8) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00, a == 1 ? 8'hFB : 8'hFF);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom) & 8'hFE;
            wr(ra[i], d);
            rd(ra[i], d & rm[i], 8'hFF);
        end
        $display("test registers done");
        for (int c = 0; c < 3; c++) begin
            for (int p = 0; p < 4; p++) begin
                wr(GTM_OFS_CLK_SEL, 8'(c));
                wr(GTM_OFS_CONTROL, {2'b00, 2'(p), 1'b0, 1'($urandom), 2'b01});
                rd(GTM_OFS_COUNT_LOW, 8'h00, 8'h00);
                repeat (126) @(posedge core_clk_i);
                rd(GTM_OFS_COUNT_LOW, cap + 8'(128 / (per[c] << p)), 8'hFF);
            end
        end
        $display("test prescale done");
        wr(GTM_OFS_GATE_SEL, 8'h00);
        wr(GTM_OFS_CONTROL, 8'h01);
        for (int p = 0; p < 2; p++) begin
            for (int l = 0; l < 2; l++) begin
                u_far.set_gate(1'(l));
                wr(GTM_OFS_GATE_CTRL, {1'b1, 1'(p), 6'h00});
                repeat (8) @(posedge core_clk_i);
                rd(GTM_OFS_GATE_CTRL, {2'b11 & {1'b1, 1'(p)}, 3'b000, 1'(l == p), 2'b00}, 8'hFF);
                rd(GTM_OFS_COUNT_LOW, 8'h00, 8'h00);
                repeat (126) @(posedge core_clk_i);
                rd(GTM_OFS_COUNT_LOW, cap + (l == p ? 8'h80 : 8'h00), 8'hFF);
            end
        end
        wr(GTM_OFS_FLAGS, 8'h03);
        #1 check({7'h00, gate_flag}, 8'h00);
        u_far.set_gate(1'b0);
        repeat (8) @(posedge core_clk_i);
        #1 check({7'h00, gate_flag}, 8'h01);
        $display("test gate done");
        wr(GTM_OFS_GATE_CTRL, 8'h00);
        for (int b = 0; b < 2; b++) begin
            wr(GTM_OFS_CONTROL, 8'h00);
            wr(GTM_OFS_COUNT_LOW, 8'hF0);
            wr(GTM_OFS_COUNT_HIGH, 8'h00);
            wr(GTM_OFS_CONTROL, {6'h00, 1'(b), 1'b1});
            rd(GTM_OFS_COUNT_LOW, 8'h00, 8'h00);
            repeat (62) @(posedge core_clk_i);
            rd(GTM_OFS_COUNT_HIGH, 8'(1 - b), 8'hFF);
        end
        wr(GTM_OFS_CONTROL, 8'h00);
        rd(GTM_OFS_COUNT_LOW, 8'h00, 8'h00);
        repeat (30) @(posedge core_clk_i);
        rd(GTM_OFS_COUNT_LOW, cap, 8'hFF);
        $display("test buffered read done");
        wr(GTM_OFS_CONTROL, 8'h01);
        wr(GTM_OFS_GATE_CTRL, 8'hD0);
        wr(GTM_OFS_GATE_CTRL, 8'hD8);
        rd(GTM_OFS_GATE_CTRL, 8'hD8, 8'hFB);
        u_far.set_gate(1'b1);
        repeat (10) @(posedge core_clk_i);
        u_far.set_gate(1'b0);
        repeat (10) @(posedge core_clk_i);
        rd(GTM_OFS_GATE_CTRL, 8'hD0, 8'hFB);
        rd(GTM_OFS_COUNT_LOW, 8'h00, 8'h00);
        u_far.set_gate(1'b1);
        repeat (10) @(posedge core_clk_i);
        rd(GTM_OFS_COUNT_LOW, cap, 8'hFF);
        wr(GTM_OFS_GATE_CTRL, 8'hD8);
        wr(GTM_OFS_GATE_CTRL, 8'hC0);
        rd(GTM_OFS_GATE_CTRL, 8'hC0, 8'hFB);
        $display("test single pulse done");
        wr(GTM_OFS_GATE_CTRL, 8'hE0);
        u_far.set_gate(1'b0);
        u_far.set_gate(1'b1);
        repeat (2) @(posedge core_clk_i);
        rd(GTM_OFS_GATE_CTRL, 8'hE4, 8'hFF);
        u_far.set_gate(1'b0);
        repeat (2) @(posedge core_clk_i);
        rd(GTM_OFS_GATE_CTRL, 8'hE4, 8'hFF);
        wr(GTM_OFS_GATE_CTRL, 8'hC0);
        rd(GTM_OFS_GATE_CTRL, 8'hC0, 8'hFF);
        $display("test toggle done");
        wr(GTM_OFS_GATE_CTRL, 8'h00);
        wr(GTM_OFS_GATE_SEL, {3'h0, GTM_GS_SELF});
        rd(GTM_OFS_GATE_CTRL, 8'h04, 8'hFF);
        wr(GTM_OFS_GATE_SEL, 8'h19);
        rd(GTM_OFS_GATE_CTRL, 8'h04, 8'hFF);
        wr(GTM_OFS_GATE_SEL, 8'h00);
        wr(GTM_OFS_CLK_SEL, {4'h0, GTM_CS_SELF});
        rd(GTM_OFS_COUNT_LOW, 8'h00, 8'h00);
        repeat (30) @(posedge core_clk_i);
        rd(GTM_OFS_COUNT_LOW, cap, 8'hFF);
        wr(GTM_OFS_CLK_SEL, {4'h0, GTM_CS_FOSC});
        $display("test reserved codes done");
        wr(GTM_OFS_GATE_CTRL, 8'h00);
        wr(GTM_OFS_CONTROL, 8'h00);
        wr(GTM_OFS_COUNT_LOW, 8'hF0);
        wr(GTM_OFS_COUNT_HIGH, 8'hFF);
        wr(GTM_OFS_FLAGS, 8'h03);
        wr(GTM_OFS_CONTROL, 8'h01);
        for (int i = 0; i < 64 && ovf_pulse !== 1'b1; i++) begin
            @(posedge core_clk_i);
            #1;
        end
        check({7'h00, ovf_pulse}, 8'h01);
        @(posedge core_clk_i);
        #1 check({7'h00, ovf_flag}, 8'h01);
        wr(GTM_OFS_FLAGS, 8'h01);
        #1 check({7'h00, ovf_flag}, 8'h00);
        $display("test overflow done");
        repeat (4) @(posedge core_clk_i);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
